// ### ocp_map.vh
// Register offsets, field positions, reset values and mode codes of the compare channel bank
`ifndef OCP_MAP_VH
`define OCP_MAP_VH

// Channel count and address layout
`define OCP_NUM_CH          8
`define OCP_ADR_W           8
`define OCP_CH_STRIDE_LOG2  4
`define OCP_CTL_OFS         4'h0
`define OCP_MAIN_OFS        4'h4
`define OCP_SEC_OFS         4'h8
`define OCP_FLAG_ADR        8'h80

// Control register fields
`define OCP_MODE_LSB        0
`define OCP_MODE_MSB        2
`define OCP_TSEL_BIT        3
`define OCP_FAULT_BIT       4
`define OCP_SIDL_BIT        13

// Reset values
`define OCP_CTL_RST         16'h0000
`define OCP_CMP_RST         16'h0000
`define OCP_FAULT_SYNC_RST  8'hFF

// Compare mode codes
`define OCP_MODE_OFF        3'h0
`define OCP_MODE_LOW        3'h1
`define OCP_MODE_HIGH       3'h2
`define OCP_MODE_TOGGLE     3'h3
`define OCP_MODE_ONE_PULSE  3'h4
`define OCP_MODE_CONT_PULSE 3'h5
`define OCP_MODE_PWM        3'h6
`define OCP_MODE_PWM_FAULT  3'h7

`endif

// ### ocp_sync.v
// Two-stage synchroniser for the eight fault input pins
`timescale 1ns/1ps
`include "ocp_map.vh"

module ocp_sync (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // Asynchronous levels and synchronised copy
  input  wire [7:0] async_i,
  output reg  [7:0] sync_o
);

  reg [7:0] meta_r;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= `OCP_FAULT_SYNC_RST;
      sync_o <= `OCP_FAULT_SYNC_RST;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule // ocp_sync

// ### ocp_top.v
// Eight-channel output compare and PWM bank with a classic Wishbone register slave
`timescale 1ns/1ps
`include "ocp_map.vh"

// Summary of operation
// - Channel time base: first or second timer
// - Timer select sits at control bit 3
// - Modes 001/010/011: low, high, toggle on match
// - Main compare equals timer count triggers action
// - Timer wrap before match leaves pin unchanged
// - Modes 100/101: main starts, secondary ends pulse
// - New single pulse only after rewriting 100
// - PWM modes: main is latch, secondary buffer
// - Mode 111: low fault tri-states pin
// - Fault flag readable at control bit 4
// - Fault clears on removal plus mode rewrite
// - PWM period follows timer period plus one
// - Period rollover: set pin, latch duty, event
// - Duty zero keeps pin low whole period
// - Duty above period keeps pin high
// - Sleep freezes channel, pin holds its level
// - Idle runs only if both stop bits clear
// - Eight channels, each with own control
// - Non-PWM compare sets sticky flag until cleared
// - PWM never sets the compare flag
module ocp_top (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // First timer
  input  wire [15:0] tmr_a_count_i,
  input  wire [15:0] tmr_a_period_i,
  input  wire        tmr_a_tick_i,
  input  wire        tmr_a_run_i,
  input  wire        tmr_a_idle_stop_i,
  // Second timer
  input  wire [15:0] tmr_b_count_i,
  input  wire [15:0] tmr_b_period_i,
  input  wire        tmr_b_tick_i,
  input  wire        tmr_b_run_i,
  input  wire        tmr_b_idle_stop_i,
  // CPU power state
  input  wire        cpu_sleep_i,
  input  wire        cpu_idle_i,
  // Fault pins, active low
  input  wire [7:0]  fault_input_pin_n_i,
  // Compare output pins
  output reg  [7:0]  compare_output_pin_o,
  output reg  [7:0]  compare_output_pin_oe_o,
  // Status towards interrupt controller and timers
  output reg  [7:0]  compare_irq_flag_o,
  output reg  [1:0]  timer_period_evt_o
);

  // Channel state
  reg  [2:0]  mode_r    [0:7];
  reg         tsel_r    [0:7];
  reg         sidl_r    [0:7];
  reg  [15:0] main_r    [0:7];
  reg  [15:0] sec_r     [0:7];
  reg  [7:0]  fault_r;
  reg  [7:0]  done_r;

  // Next values
  reg  [2:0]  mode_nxt  [0:7];
  reg         tsel_nxt  [0:7];
  reg         sidl_nxt  [0:7];
  reg  [15:0] main_nxt  [0:7];
  reg  [15:0] sec_nxt   [0:7];
  reg  [7:0]  fault_nxt;
  reg  [7:0]  done_nxt;
  reg  [7:0]  pin_nxt;
  reg  [7:0]  oe_nxt;
  reg  [7:0]  flag_nxt;
  reg  [1:0]  tevt_nxt;
  reg  [31:0] rd_nxt;

  // Per-channel working values
  reg  [15:0] c_cnt;
  reg  [15:0] c_per;
  reg         c_tick;
  reg         c_run;
  reg         c_ev;
  reg         c_hit_main;
  reg         c_hit_sec;
  reg         c_wr_ctl;
  reg         c_wr_main;
  reg         c_wr_sec;
  reg  [2:0]  c_mode_after;

  // Bus decode
  wire        bus_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        bus_wr     = bus_req & wb_we_i;
  wire        in_ch_area = ~wb_adr_i[7];
  wire [2:0]  bus_ch     = wb_adr_i[6:4];
  wire [3:0]  bus_ofs    = wb_adr_i[3:0];
  wire        flag_wr    = bus_wr & (wb_adr_i == `OCP_FLAG_ADR) & wb_sel_i[0];

  wire [7:0]  fault_sync;

  integer i;

  // Fault pins come from outside the clock domain
  ocp_sync u_fault_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (fault_input_pin_n_i),
    .sync_o  (fault_sync)
  );

  // Byte-lane merge of a 16-bit register
  function [15:0] lane_merge;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0]  sel;
    begin
      lane_merge[7:0]  = sel[0] ? new_v[7:0]  : old_v[7:0];
      lane_merge[15:8] = sel[1] ? new_v[15:8] : old_v[15:8];
    end
  endfunction

  // Choose between the two timers
  function [15:0] pick16;
    input        sel;
    input [15:0] a_v;
    input [15:0] b_v;
    begin
      pick16 = sel ? b_v : a_v;
    end
  endfunction

  function is_pwm;
    input [2:0] mode;
    begin
      is_pwm = (mode == `OCP_MODE_PWM) | (mode == `OCP_MODE_PWM_FAULT);
    end
  endfunction

  function [15:0] ctl_word;
    input [2:0] mode;
    input       tsel;
    input       fault;
    input       sidl;
    begin
      ctl_word = `OCP_CTL_RST;
      ctl_word[`OCP_MODE_MSB:`OCP_MODE_LSB] = mode;
      ctl_word[`OCP_TSEL_BIT]  = tsel;
      ctl_word[`OCP_FAULT_BIT] = fault;
      ctl_word[`OCP_SIDL_BIT]  = sidl;
    end
  endfunction

  // Channel behaviour and register writes
  always @* begin
    fault_nxt    = fault_r;
    done_nxt     = done_r;
    pin_nxt      = compare_output_pin_o;
    oe_nxt       = compare_output_pin_oe_o;
    flag_nxt     = compare_irq_flag_o;
    tevt_nxt     = 2'b00;
    c_cnt        = 16'h0000;
    c_per        = 16'h0000;
    c_tick       = 1'b0;
    c_run        = 1'b0;
    c_ev         = 1'b0;
    c_hit_main   = 1'b0;
    c_hit_sec    = 1'b0;
    c_wr_ctl     = 1'b0;
    c_wr_main    = 1'b0;
    c_wr_sec     = 1'b0;
    c_mode_after = `OCP_MODE_OFF;
    for (i = 0; i < `OCP_NUM_CH; i = i + 1) begin
      mode_nxt[i] = mode_r[i];
      tsel_nxt[i] = tsel_r[i];
      sidl_nxt[i] = sidl_r[i];
      main_nxt[i] = main_r[i];
      sec_nxt[i]  = sec_r[i];

      // Time base of this channel
      c_cnt  = pick16(tsel_r[i], tmr_a_count_i, tmr_b_count_i);
      c_per  = pick16(tsel_r[i], tmr_a_period_i, tmr_b_period_i);
      c_tick = tsel_r[i] ? tmr_b_tick_i : tmr_a_tick_i;
      // Sleep stops all timer events of the channel; idle needs all stop bits clear
      c_run  = ~cpu_sleep_i & (~cpu_idle_i | (~sidl_r[i] & (tsel_r[i] ? (tmr_b_run_i & ~tmr_b_idle_stop_i)
                                                                  : (tmr_a_run_i & ~tmr_a_idle_stop_i))));
      c_ev       = c_run & c_tick;
      c_hit_main = c_ev & (c_cnt == main_r[i]);
      c_hit_sec  = c_ev & (c_cnt == sec_r[i]);

      // Software clear first, so a same-cycle compare set wins
      if (flag_wr & wb_dat_i[i]) begin
        flag_nxt[i] = 1'b0;
      end

      case (mode_r[i])
        `OCP_MODE_OFF: begin
          pin_nxt[i] = 1'b0;
        end
        `OCP_MODE_LOW: begin
          if (c_hit_main) begin
            pin_nxt[i]  = 1'b0;
            flag_nxt[i] = 1'b1;
          end
        end
        `OCP_MODE_HIGH: begin
          if (c_hit_main) begin
            pin_nxt[i]  = 1'b1;
            flag_nxt[i] = 1'b1;
          end
        end
        `OCP_MODE_TOGGLE: begin
          if (c_hit_main) begin
            pin_nxt[i]  = ~compare_output_pin_o[i];
            flag_nxt[i] = 1'b1;
          end
        end
        `OCP_MODE_ONE_PULSE, `OCP_MODE_CONT_PULSE: begin
          if (~done_r[i]) begin
            if (c_hit_main) begin
              pin_nxt[i] = 1'b1;
            end
            if (c_hit_sec) begin
              pin_nxt[i]  = 1'b0;
              flag_nxt[i] = 1'b1;
              if (mode_r[i] == `OCP_MODE_ONE_PULSE) begin
                done_nxt[i] = 1'b1;
              end
            end
          end
        end
        `OCP_MODE_PWM, `OCP_MODE_PWM_FAULT: begin
          // Compare flag untouched in PWM
          if (c_ev & (c_cnt == c_per)) begin
            main_nxt[i] = sec_r[i];
            pin_nxt[i]  = (sec_r[i] != 16'h0000);
            tevt_nxt[tsel_r[i]] = 1'b1;
          end else if (c_ev & (({1'b0, c_cnt} + 17'h0_0001) == {1'b0, main_r[i]})) begin
            pin_nxt[i] = 1'b0;
          end
        end
        default: begin
          pin_nxt[i] = 1'b0;
        end
      endcase

      // Software access to this channel
      c_wr_ctl  = bus_wr & in_ch_area & (bus_ch == i[2:0]) & (bus_ofs == `OCP_CTL_OFS);
      c_wr_main = bus_wr & in_ch_area & (bus_ch == i[2:0]) & (bus_ofs == `OCP_MAIN_OFS);
      c_wr_sec  = bus_wr & in_ch_area & (bus_ch == i[2:0]) & (bus_ofs == `OCP_SEC_OFS);
      if (c_wr_ctl & wb_sel_i[0]) begin
        mode_nxt[i] = wb_dat_i[`OCP_MODE_MSB:`OCP_MODE_LSB];
        tsel_nxt[i] = wb_dat_i[`OCP_TSEL_BIT];
        pin_nxt[i]  = 1'b0;
        done_nxt[i] = 1'b0;
      end
      if (c_wr_ctl & wb_sel_i[1]) begin
        sidl_nxt[i] = wb_dat_i[`OCP_SIDL_BIT];
      end
      // Main register is a read-only latch in PWM
      if (c_wr_main & ~is_pwm(mode_r[i])) begin
        main_nxt[i] = lane_merge(main_r[i], wb_dat_i[15:0], wb_sel_i[1:0]);
      end
      if (c_wr_sec) begin
        sec_nxt[i] = lane_merge(sec_r[i], wb_dat_i[15:0], wb_sel_i[1:0]);
      end

      // Fault latch: set wins, cleared by removal plus mode rewrite
      c_mode_after = mode_nxt[i];
      fault_nxt[i] = ((c_mode_after == `OCP_MODE_PWM_FAULT) & ~fault_sync[i]) |
                     (fault_r[i] & ~(c_wr_ctl & wb_sel_i[0] & is_pwm(c_mode_after) & fault_sync[i]));
      oe_nxt[i] = (c_mode_after != `OCP_MODE_OFF) & ~fault_nxt[i];
    end
  end

  // Read data
  always @* begin
    rd_nxt = 32'h0000_0000;
    if (in_ch_area) begin
      case (bus_ofs)
        `OCP_CTL_OFS:  rd_nxt[15:0] = ctl_word(mode_r[bus_ch], tsel_r[bus_ch], fault_r[bus_ch],
                                               sidl_r[bus_ch]);
        `OCP_MAIN_OFS: rd_nxt[15:0] = main_r[bus_ch];
        `OCP_SEC_OFS:  rd_nxt[15:0] = sec_r[bus_ch];
        default:       rd_nxt = 32'h0000_0000;
      endcase
    end else if (wb_adr_i == `OCP_FLAG_ADR) begin
      rd_nxt[7:0] = compare_irq_flag_o;
    end
  end

  // State registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < `OCP_NUM_CH; i = i + 1) begin
        mode_r[i] <= `OCP_MODE_OFF;
        tsel_r[i] <= 1'b0;
        sidl_r[i] <= 1'b0;
        main_r[i] <= `OCP_CMP_RST;
        sec_r[i]  <= `OCP_CMP_RST;
      end
      fault_r                 <= 8'h00;
      done_r                  <= 8'h00;
      compare_output_pin_o    <= 8'h00;
      compare_output_pin_oe_o <= 8'h00;
      compare_irq_flag_o      <= 8'h00;
      timer_period_evt_o      <= 2'b00;
      wb_ack_o                <= 1'b0;
      wb_dat_o                <= 32'h0000_0000;
    end else begin
      for (i = 0; i < `OCP_NUM_CH; i = i + 1) begin
        mode_r[i] <= mode_nxt[i];
        tsel_r[i] <= tsel_nxt[i];
        sidl_r[i] <= sidl_nxt[i];
        main_r[i] <= main_nxt[i];
        sec_r[i]  <= sec_nxt[i];
      end
      fault_r                 <= fault_nxt;
      done_r                  <= done_nxt;
      compare_output_pin_o    <= pin_nxt;
      compare_output_pin_oe_o <= oe_nxt;
      compare_irq_flag_o      <= flag_nxt;
      timer_period_evt_o      <= tevt_nxt;
      wb_ack_o                <= bus_req;
      wb_dat_o                <= bus_req ? rd_nxt : 32'h0000_0000;
    end
  end

endmodule // ocp_top

// ### ocp_load_model.sv
// External load on the compare pins, pulled down where undriven
`timescale 1ns/1ps
module ocp_load_model (
  // Pin drive from the bank
  input  wire logic [7:0] pin_i,
  input  wire logic [7:0] oe_i,
  // Level seen by the load
  output wire logic [7:0] level_o
);
  assign level_o = pin_i & oe_i;
endmodule // ocp_load_model

// ### ocp_top_properties.sv
// Port-level checks of the compare bank
`timescale 1ns/1ps
module ocp_top_properties (
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Timers, power and outputs
  input wire logic        tmr_a_tick_i,
  input wire logic        tmr_b_tick_i,
  input wire logic        cpu_sleep_i,
  input wire logic [7:0]  compare_output_pin_o,
  input wire logic [7:0]  compare_output_pin_oe_o,
  input wire logic [7:0]  compare_irq_flag_o,
  input wire logic [1:0]  timer_period_evt_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire tick = tmr_a_tick_i | tmr_b_tick_i;
  wire wr   = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack; s_req |=> s_ans; endproperty
  a_ack: assert property (p_ack) else $error("ack is not one cycle after request");
  property p_dat; wb_dat_o[31:16] == 16'h0000 && (wb_ack_o || wb_dat_o == 32'h0000_0000); endproperty
  a_dat: assert property (p_dat) else $error("read data outside ack");
  property p_evt; timer_period_evt_o[0] |-> $past(tmr_a_tick_i); endproperty
  a_evt: assert property (p_evt) else $error("period event without tick");
  property p_evb; timer_period_evt_o[1] |-> $past(tmr_b_tick_i); endproperty
  a_evb: assert property (p_evb) else $error("second period event without tick");
  property p_set; |(compare_irq_flag_o & ~$past(compare_irq_flag_o)) |-> $past(tick); endproperty
  a_set: assert property (p_set) else $error("flag set without tick");
  property p_clr; |($past(compare_irq_flag_o) & ~compare_irq_flag_o) |-> $past(wr && wb_adr_i == 8'h80); endproperty
  a_clr: assert property (p_clr) else $error("flag dropped without clear");
  property p_oe; |(compare_output_pin_oe_o & ~$past(compare_output_pin_oe_o)) |-> $past(wr); endproperty
  a_oe: assert property (p_oe) else $error("drive enabled without write");
  property p_pin; !$stable(compare_output_pin_o) |-> $past(tick | wr); endproperty
  a_pin: assert property (p_pin) else $error("pin moved without event");
  property p_slp; cpu_sleep_i && !wr |=> $stable(compare_output_pin_o) && timer_period_evt_o == 2'b00; endproperty
  a_slp: assert property (p_slp) else $error("activity during sleep");
endmodule // ocp_top_properties

// ### testbench.sv
// Self-checking bench for the compare and PWM bank
`timescale 1ns/1ps
module testbench;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic        ka = 0, kb = 0, slp = 0, idl = 0, pv, trn = 1, tis = 0;
  logic [7:0]  adr = 0, fault_n = 8'hFF;
  logic [15:0] ca = 0, cb = 0, per = 3, v;
  logic [31:0] dwr = 0, q;
  wire  [31:0] dat;
  wire  [7:0]  pin, oe, flg, lvl;
  wire  [1:0]  evt;
  wire         ack;
  integer      n_mismatch = 0, check_count = 0, seed = 67, m, i;
  int          dty [3] = '{0, 2, 5};
  ocp_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dwr), .wb_dat_o(dat), .wb_ack_o(ack),
    .tmr_a_count_i(ca), .tmr_a_period_i(per), .tmr_a_tick_i(ka), .tmr_a_run_i(trn),
    .tmr_a_idle_stop_i(tis), .tmr_b_count_i(cb), .tmr_b_period_i(per), .tmr_b_tick_i(kb),
    .tmr_b_run_i(1'b1), .tmr_b_idle_stop_i(1'b0), .cpu_sleep_i(slp), .cpu_idle_i(idl),
    .fault_input_pin_n_i(fault_n), .compare_output_pin_o(pin), .compare_output_pin_oe_o(oe),
    .compare_irq_flag_o(flg), .timer_period_evt_o(evt));
  ocp_load_model load (.pin_i(pin), .oe_i(oe), .level_o(lvl));
  initial forever #50 clk_i = ~clk_i;
  task report_and_stop;
    $display("mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task ck(input [31:0] g, e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task wb(input [7:0] a, input [31:0] d, input w);
    integer k;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we  <= w;
    adr <= a;
    dwr <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1 && k < 20);
    q = dat;
    cyc <= 0;
    stb <= 0;
    ck(ack, 1);
    if (ack !== 1) report_and_stop;
  endtask
  // One timer advance; b picks the second timer
  task tk(input b, input [15:0] c);
    @(posedge clk_i);
    ca <= c;
    cb <= c;
    ka <= !b;
    kb <= b;
    @(posedge clk_i);
    ka <= 0;
    kb <= 0;
    @(negedge clk_i);
  endtask
  function logic pwm(input logic p, input [15:0] c, d);
    if (c == per) return d != 0;
    if (c + 16'h0001 == d) return 0;
    return p;
  endfunction
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    wb(8'h7C, 0, 0);
    ck(q, 0);
    for (m = 0; m < 8; m++) begin
      v = {$random(seed)} & 16'h2008;
      wb(8'(m * 16), 0, 0);
      ck(q, 0);
      wb(8'(m * 16), v | 16'h0010, 1);
      wb(8'(m * 16), 0, 0);
      ck(q, v);
    end
    ck(oe, 8'h00);
    for (m = 1; m < 4; m++) begin
      v = {$random(seed)} % 200 + 2;
      wb(8'h04, v, 1);
      wb(8'h00, m, 1);
      tk(1, v);
      ck(lvl[0], 0);
      tk(0, v - 1);
      tk(0, 0);
      ck(lvl[0], 0);
      tk(0, v);
      ck(lvl[0], m != 1);
      ck(flg[0], 1);
      wb(8'h80, 1, 1);
      ck(flg[0], 0);
    end
    idl <= 1;
    trn <= 0;
    wb(8'h00, 16'h0002, 1);
    tk(0, v);
    ck(lvl[0], 0);
    wb(8'h00, 16'h0002, 1);
    trn <= 1;
    tis <= 1;
    tk(0, v);
    ck(lvl[0], 0);
    wb(8'h00, 16'h2002, 1);
    tis <= 0;
    tk(0, v);
    ck(lvl[0], 0);
    wb(8'h00, 2, 1);
    tk(0, v);
    ck(lvl[0], 1);
    idl <= 0;
    per <= 6;
    wb(8'h04, 3, 1);
    wb(8'h08, 6, 1);
    for (m = 4; m < 6; m++) begin
      wb(8'h00, m, 1);
      for (i = 0; i < 3; i++) begin
        tk(0, 3);
        ck(lvl[0], m == 5 || i == 0);
        tk(0, 6);
        ck(lvl[0], 0);
      end
    end
    wb(8'h00, 4, 1);
    tk(0, 3);
    ck(lvl[0], 1);
    wb(8'h80, 1, 1);
    per <= 3;
    for (m = 0; m < 3; m++) begin
      wb(8'h08, dty[m], 1);
      wb(8'h00, 6, 1);
      pv = 0;
      for (i = 0; i < 8; i++) begin
        tk(0, (i + 3) % 4);
        pv = pwm(pv, (i + 3) % 4, dty[m]);
        ck(lvl[0], pv);
        ck(evt[0], i % 4 == 0);
      end
      wb(8'h04, 16'hFFFF, 1);
      wb(8'h04, 0, 0);
      ck(q, dty[m]);
      ck(flg[0], 0);
    end
    wb(8'h08, 0, 1);
    slp <= 1;
    tk(0, 3);
    ck(lvl[0], 1);
    @(posedge clk_i);
    slp <= 0;
    tk(0, 3);
    ck(lvl[0], 0);
    wb(8'h28, 2, 1);
    wb(8'h20, 16'h000E, 1);
    tk(1, 3);
    ck(evt, 2'b10);
    ck(lvl[2], 1);
    wb(8'h18, 2, 1);
    wb(8'h10, 7, 1);
    tk(0, 3);
    ck(lvl[1], 1);
    @(posedge clk_i);
    fault_n <= 8'hFD;
    repeat (4) @(posedge clk_i);
    wb(8'h10, 0, 0);
    ck(q, 16'h0017);
    ck(oe[1], 0);
    wb(8'h10, 7, 1);
    ck(oe[1], 0);
    fault_n <= 8'hFF;
    repeat (4) @(posedge clk_i);
    ck(oe[1], 0);
    wb(8'h10, 7, 1);
    ck(oe[1], 1);
    report_and_stop;
  end
endmodule // testbench
bind ocp_top ocp_top_properties chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .tmr_a_tick_i(tmr_a_tick_i), .tmr_b_tick_i(tmr_b_tick_i),
  .cpu_sleep_i(cpu_sleep_i), .compare_output_pin_o(compare_output_pin_o),
  .compare_output_pin_oe_o(compare_output_pin_oe_o), .compare_irq_flag_o(compare_irq_flag_o),
  .timer_period_evt_o(timer_period_evt_o));
